// ===== bench/fdsor_assertions.sv
// Concurrent checks on the floppy status and output register bank
`timescale 1ns/1ns
`include "fdsor_defines.vh"

module fdsor_assertions (
    // Clock, reset, mode
    input wire i_mclk,
    input wire i_reset,
    input wire [1:0] i_status_mode,
    // Host port
    input wire [9:0] i_addr,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    input wire o_rdata_oe,
    // Core levels
    input wire i_step_dir,
    input wire i_head_side_select,
    input wire i_dma_request,
    input wire i_disk_interrupt_out,
    // Drive and pin outputs
    input wire o_drive_select_0_n,
    input wire o_drive_select_1_n,
    input wire o_motor_out_0,
    input wire o_soft_reset_n,
    input wire o_dma_request_oe,
    input wire o_disk_interrupt_oe
);
    wire ext = i_status_mode == `FDSOR_MODE_EXT;
    wire alt = i_status_mode == `FDSOR_MODE_ALT;
    wire rd_a = i_rd && i_addr == `FDSOR_ADDR_STATUS_A;
    wire rd_b = i_rd && i_addr == `FDSOR_ADDR_STATUS_B;
    wire rd_o = i_rd && i_addr == `FDSOR_ADDR_OUTPUT;
    wire wr_o = i_wr && i_addr == `FDSOR_ADDR_OUTPUT;

    // ==========================================================
    // Checks, all on the one clock
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    a_out_read: assert property (
        rd_o |=> o_rdata_oe && o_rdata[7:6] == 2'h0) else $error("motor 2/3 bits not zero");
    a_basic_float: assert property (
        !ext && !alt && (rd_a || rd_b) |=> !o_rdata_oe) else $error("basic status read driven");
    a_sel_single: assert property (
        o_drive_select_0_n || o_drive_select_1_n) else $error("two drives selected");
    a_ext_pins_on: assert property (
        ext |-> o_dma_request_oe && o_disk_interrupt_oe)
        else $error("pins disabled in extended mode");
    a_write_motor: assert property (
        wr_o |-> ##2 o_motor_out_0 == $past(i_wdata[4], 2)
        && o_soft_reset_n == $past(i_wdata[2], 2)) else $error("motor or reset not written");
    a_pin_gate: assert property (
        wr_o && !ext |-> ##2 o_dma_request_oe == $past(i_wdata[3], 2))
        else $error("pin enable not following bit 3");
    a_ext_status_a: assert property (
        ext && rd_a |=> o_rdata[6] && o_rdata[0] == $past(i_step_dir)
        && o_rdata[7] == $past(i_disk_interrupt_out)) else $error("extended status A wrong");
    a_alt_status_a: assert property (
        alt && rd_a |=> o_rdata[3] != $past(i_head_side_select)
        && o_rdata[6] == $past(i_dma_request)) else $error("alternate status A wrong");
endmodule

bind fdsor_top fdsor_assertions fdsor_assertions_i (.*);

// ===== bench/fdsor_drive_model.sv
// Behavioural floppy drive 0 answering select and motor
`timescale 1ns/1ns

module fdsor_drive_model #(
    parameter WP = 1'b1
) (
    // Clock and drive controls
    input wire i_mclk,
    input wire i_sel0_n,
    input wire i_motor_out_0,
    input wire i_track_zero_in_at,
    // Drive status lines, active high
    output reg o_write_protect,
    output reg o_index,
    output reg o_track_zero_in,
    output reg o_read_data
);
    reg [3:0] phase = 4'h0;
    wire on = !i_sel0_n && i_motor_out_0;

    // Spindle position
    always @(posedge i_mclk) begin
        phase <= phase + 4'h1;
    end

    // Unselected or stopped drive holds every line low, which is inactive
    always @* begin
        o_write_protect = on && WP;
        o_track_zero_in = on && i_track_zero_in_at;
        o_index = on && phase == 4'hf;
        o_read_data = on && phase[1:0] == 2'h3;
    end
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the floppy status and output registers
`timescale 1ns/1ns
`include "fdsor_defines.vh"

module tb;
    reg i_mclk = 0, i_reset = 1, i_rd = 0, i_wr = 0, i_input_reg_read = 0;
    reg [1:0] i_status_mode = 0;
    reg [9:0] i_addr = 0;
    reg [7:0] i_wdata = 0;
    reg i_step_dir = 0, i_head_side_select = 0, i_step = 0, i_write_gate_out = 0;
    reg i_write_data = 0, i_dma_request = 0, i_disk_interrupt_out = 0;
    reg i_dma_ack_n = 1, i_terminal_count = 0, track_zero_in_at = 1;
    wire [7:0] o_rdata;
    wire o_rdata_oe, o_drive_select_0_n, o_drive_select_1_n, o_motor_out_0, o_motor_out_1;
    wire o_soft_reset_n, o_dma_request, o_dma_request_oe, o_disk_interrupt_out;
    wire o_disk_interrupt_oe, o_dma_ack_n, o_terminal_count;
    wire i_write_protect, i_index, i_track_zero_in, i_read_data;
    integer mismatches = 0, comparisons = 0, cycles = 0;
    localparam [9:0] a_sa = `FDSOR_ADDR_STATUS_A;
    localparam [9:0] a_sb = `FDSOR_ADDR_STATUS_B;
    localparam [9:0] a_out = `FDSOR_ADDR_OUTPUT;

    fdsor_top fdsor_top_i (.*);
    fdsor_drive_model fdsor_drive_model_i (.i_mclk(i_mclk), .i_sel0_n(o_drive_select_0_n),
        .i_motor_out_0(o_motor_out_0), .i_track_zero_in_at(track_zero_in_at), .o_write_protect(i_write_protect),
        .o_index(i_index), .o_track_zero_in(i_track_zero_in), .o_read_data(i_read_data));

    // Clock and hang limit, far above the roughly 110 cycles needed
    always #2 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end

    // ==========================================================
    // Access tasks
    task tick(input integer n);
        begin
            repeat (n) @(posedge i_mclk);
            #1;
        end
    endtask
    task chk(input [7:0] s, input [7:0] e);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                mismatches = mismatches + 1;
                $display("Error %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task rst(input [1:0] m);
        begin
            i_reset = 1;
            i_status_mode = m;
            tick(2);
            chk({o_dma_request_oe, o_disk_interrupt_oe}, (m == `FDSOR_MODE_EXT) ? 8'h03 : 8'h00);
            i_reset = 0;
        end
    endtask
    // Leading tick keeps strobes from being set twice in one step
    task wr(input [7:0] d);
        begin
            tick(1);
            i_wr = 1;
            i_addr = a_out;
            i_wdata = d;
            tick(1);
            i_wr = 0;
        end
    endtask
    task rd(input [9:0] a, input [7:0] e, input [7:0] m, input oe);
        begin
            tick(1);
            i_rd = 1;
            i_addr = a;
            tick(1);
            i_rd = 0;
            chk(o_rdata_oe, oe);
            if (oe) chk(o_rdata & m, e);
        end
    endtask
    task report_and_stop;
        begin
            if (mismatches == 0 && comparisons > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        rst(`FDSOR_MODE_EXT);
        tick(3);
        rd(a_out, 8'h00, 8'hff, 1);
        rd(a_sb, 8'hc0, 8'hff, 1);
        chk(o_dma_request_oe, 1);
        chk({o_dma_request, o_disk_interrupt_out}, 8'h00);
        i_write_data = 1;
        tick(1);
        i_write_data = 0;
        rd(a_sb, 8'hd0, 8'hff, 1);
        wr(8'h1c);
        tick(2);
        chk({o_drive_select_1_n, o_drive_select_0_n, o_motor_out_1, o_motor_out_0,
            o_soft_reset_n}, 8'h13);
        i_step_dir = 1;
        i_head_side_select = 1;
        i_disk_interrupt_out = 1;
        tick(4);
        rd(a_sa, 8'hc9, 8'hfb, 1);
        rd(a_sb, 8'hc1, 8'he7, 1);
        wr(8'hff);
        tick(2);
        chk({o_drive_select_1_n, o_drive_select_0_n}, 8'h03);
        rd(a_out, 8'h3f, 8'hff, 1);
        wr(8'h2d);
        tick(2);
        chk({o_drive_select_1_n, o_drive_select_0_n, o_motor_out_1, o_motor_out_0},
            8'h06);
        rd(a_sb, 8'he2, 8'he7, 1);
        wr(8'h29);
        wr(8'h2d);
        chk({o_soft_reset_n, o_motor_out_1}, 8'h01);
        tick(1);
        chk({o_soft_reset_n, o_motor_out_1}, 8'h03);
        rst(`FDSOR_MODE_BASIC);
        rd(a_sa, 8'h00, 8'h00, 0);
        rd(a_sb, 8'h00, 8'h00, 0);
        i_dma_ack_n = 0;
        i_terminal_count = 1;
        i_dma_request = 1;
        tick(4);
        chk({o_dma_request_oe, o_disk_interrupt_oe, o_dma_ack_n, o_terminal_count},
            8'h02);
        wr(8'h1c);
        tick(4);
        chk({o_dma_request_oe, o_disk_interrupt_oe, o_dma_ack_n, o_terminal_count},
            8'h0d);
        chk({o_dma_request, o_disk_interrupt_out}, 8'h03);
        rst(`FDSOR_MODE_ALT);
        wr(8'h1c);
        tick(4);
        rd(a_sa, 8'hd2, 8'hfb, 1);
        i_step = 1;
        i_write_gate_out = 1;
        i_write_data = 1;
        tick(1);
        i_step = 0;
        i_write_gate_out = 0;
        i_write_data = 0;
        rd(a_sa, 8'hf2, 8'hfb, 1);
        rd(a_sa, 8'hf2, 8'hfb, 1);
        rd(a_sb, 8'hd7, 8'hf7, 1);
        i_input_reg_read = 1;
        tick(1);
        i_input_reg_read = 0;
        rd(a_sa, 8'hd2, 8'hfb, 1);
        rd(a_sb, 8'hc3, 8'hf7, 1);
        i_write_data = 1;
        tick(1);
        i_write_data = 0;
        rd(a_sb, 8'hd3, 8'hf7, 1);
        // Deselect drive 0 so read data goes quiet, then clear the latches
        wr(8'h0d);
        tick(6);
        i_input_reg_read = 1;
        tick(1);
        i_input_reg_read = 0;
        rd(a_sb, 8'ha3, 8'hff, 1);
        // Reselect drive 0; its read pulses must set the read data latch
        wr(8'h1c);
        tick(8);
        rd(a_sb, 8'hcb, 8'hff, 1);
        // Step latch set, then cleared by a soft reset through bit 2
        i_step = 1;
        tick(1);
        i_step = 0;
        rd(a_sa, 8'hf2, 8'hfb, 1);
        wr(8'h18);
        rd(a_sa, 8'hd2, 8'hfb, 1);
        report_and_stop;
    end
endmodule

// ===== verilog/fdsor_defines.vh
// Constants for the floppy status and output register bank
//
// Overview of operation
// - Extended mode, status A bit 0 shows step direction, 1 means inward.
// - Extended mode, status A bits 1,2,4 inverted inputs; bits 3,5 side, step.
// - Extended mode, status A bit 6 always reads 1, no second drive.
// - Status A bit 7 shows disk interrupt level in extended and alternate modes.
// - Alternate mode, status A: inverted direction and side, true inputs, DMA request.
// - Alternate mode, status A bit 5 latches step; cleared by input read or reset.
// - Basic mode leaves the data bus undriven on status reads; extended always readable.
// - Extended mode, status B bits 0-2 show motors and write gate; motors hard-reset only.
// - Extended mode, status B bits 3,4 toggle on inactive read/write data edges.
// - Extended mode, status B bit 5 mirrors output register drive select 0 bit.
// - Extended mode, status B bits 6 and 7 always read 1.
// - Alternate mode, status B bits 0, 1 and 7 always read 1.
// - Alternate mode, status B bit 2 latches write gate rise; input read clears.
// - Alternate mode, status B bits 3,4 latch data inactive edges; not write-gate qualified.
// - Alternate mode, status B bits 5,6 show drive select outputs active low.
// - Output register writable anytime, zero on hard reset, kept through soft reset.
// - Output register bits 1:0 binary select, one drive select active at most.
// - Output bit 2 low holds soft reset; host holds it at least 100 ns.
// - Basic/alternate: output bit 3 gates DMA and interrupt pins, else floated/ignored.
// - Extended mode: DMA and interrupt pins always enabled; bit 3 still resets to 0.
// - Output bits 4 and 5 drive motor 0 and motor 1 outputs active.
// - Output bits 6 and 7 are not implemented and read 0.
`ifndef FDSOR_DEFINES_VH
`define FDSOR_DEFINES_VH

// ==========================================================
// Register addresses
`define FDSOR_ADDR_STATUS_A 10'h3f0
`define FDSOR_ADDR_STATUS_B 10'h3f1
`define FDSOR_ADDR_OUTPUT 10'h3f2

// ==========================================================
// Compatibility modes
`define FDSOR_MODE_EXT 2'h0
`define FDSOR_MODE_ALT 2'h1
`define FDSOR_MODE_BASIC 2'h2

// ==========================================================
// Output register fields and reset
`define FDSOR_OUT_RESET 8'h00
`define FDSOR_OUT_SEL_HI 1
`define FDSOR_OUT_SEL_LO 0
`define FDSOR_OUT_NRST 2
`define FDSOR_OUT_DMA_PIN_ENABLE 3
`define FDSOR_OUT_MOTOR_OUT_0 4
`define FDSOR_OUT_MOTOR_OUT_1 5
`define FDSOR_OUT_IMPL 8'h3f

// ==========================================================
// Fixed read values
`define FDSOR_BYTE_ZERO 8'h00
`define FDSOR_BIT_ONE 1'b1

// ==========================================================
// Timing: least soft reset hold, host side
`define FDSOR_SRST_MIN_NS 100
`define FDSOR_CLK_NS 4
`define FDSOR_SRST_MIN_CYC ((`FDSOR_SRST_MIN_NS + `FDSOR_CLK_NS - 1) / `FDSOR_CLK_NS)

`endif

// ===== verilog/fdsor_top.v
// Floppy status registers A and B and the digital output register
`timescale 1ns/1ns
`include "fdsor_defines.vh"

module fdsor_top (
    // Clock and hardware reset
    input wire i_mclk,
    input wire i_reset,
    // Static configuration
    input wire [1:0] i_status_mode,
    // Host programmed-I/O port
    input wire [9:0] i_addr,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire i_input_reg_read,
    output reg [7:0] o_rdata,
    output reg o_rdata_oe,
    // Controller core signals, same clock
    input wire i_step_dir,
    input wire i_head_side_select,
    input wire i_step,
    input wire i_write_gate_out,
    input wire i_write_data,
    input wire i_dma_request,
    input wire i_disk_interrupt_out,
    // Drive pins, asynchronous, active high inside
    input wire i_write_protect,
    input wire i_index,
    input wire i_track_zero_in,
    input wire i_read_data,
    // Host DMA inputs, asynchronous
    input wire i_dma_ack_n,
    input wire i_terminal_count,
    // Drive outputs
    output reg o_drive_select_0_n,
    output reg o_drive_select_1_n,
    output reg o_motor_out_0,
    output reg o_motor_out_1,
    // Core reset and DMA/interrupt pin gating
    output reg o_soft_reset_n,
    output reg o_dma_request,
    output reg o_dma_request_oe,
    output reg o_disk_interrupt_out,
    output reg o_disk_interrupt_oe,
    output reg o_dma_ack_n,
    output reg o_terminal_count
);

    // ==========================================================
    // Functions
    // Drive select decode, active low, used for pins and status B
    function fdsor_ds_n;
        input [1:0] sel;
        input idx;
        begin
            fdsor_ds_n = (sel != {1'b0, idx});
        end
    endfunction

    // ==========================================================
    // State
    reg [5:0] out_reg;
    reg [5:0] sync_a;
    reg [5:0] sync_b;
    reg rdata_prev;
    reg wdata_prev;
    reg step_prev;
    reg write_gate_out_prev;
    reg rdata_toggle;
    reg wdata_toggle;
    reg step_latch;
    reg write_gate_out_latch;
    reg rdata_latch;
    reg wdata_latch;
    reg [7:0] next_status_a;
    reg [7:0] next_status_b;
    reg [7:0] next_rdata;
    reg next_oe;

    wire wp_s = sync_b[0];
    wire idx_s = sync_b[1];
    wire track_zero_in_s = sync_b[2];
    wire rdata_s = sync_b[3];
    wire dack_n_s = sync_b[4];
    wire tc_s = sync_b[5];
    wire mode_ext = (i_status_mode == `FDSOR_MODE_EXT);
    wire mode_alt = (i_status_mode == `FDSOR_MODE_ALT);
    wire soft_rst = ~out_reg[`FDSOR_OUT_NRST];
    wire [1:0] sel = out_reg[`FDSOR_OUT_SEL_HI:`FDSOR_OUT_SEL_LO];
    wire pins_en = mode_ext | out_reg[`FDSOR_OUT_DMA_PIN_ENABLE];
    wire rdata_fall = rdata_prev & ~rdata_s;
    wire wdata_fall = wdata_prev & ~i_write_data;
    wire step_rise = i_step & ~step_prev;
    wire write_gate_out_rise = i_write_gate_out & ~write_gate_out_prev;

    // ==========================================================
    // Pin synchronisers; stage a is read only by stage b
    always @(posedge i_mclk) begin
        if (i_reset) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {i_terminal_count, i_dma_ack_n, i_read_data,
                i_track_zero_in, i_index, i_write_protect};
            sync_b <= sync_a;
        end
    end

    // ==========================================================
    // Output register: written any time, kept through soft reset
    always @(posedge i_mclk) begin
        if (i_reset) begin
            out_reg <= 6'h00;
        end else if (i_wr && i_addr == `FDSOR_ADDR_OUTPUT) begin
            out_reg <= i_wdata[5:0];
        end
    end

    // ==========================================================
    // Edge history and toggle bits
    always @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_prev <= 1'b0;
            wdata_prev <= 1'b0;
            step_prev <= 1'b0;
            write_gate_out_prev <= 1'b0;
            rdata_toggle <= 1'b0;
            wdata_toggle <= 1'b0;
        end else begin
            rdata_prev <= rdata_s;
            wdata_prev <= i_write_data;
            step_prev <= i_step;
            write_gate_out_prev <= i_write_gate_out;
            if (rdata_fall)
                rdata_toggle <= ~rdata_toggle;
            if (wdata_fall)
                wdata_toggle <= ~wdata_toggle;
        end
    end

    // ==========================================================
    // Sticky latches; a set in the clearing cycle wins
    always @(posedge i_mclk) begin
        if (i_reset) begin
            step_latch <= 1'b0;
            write_gate_out_latch <= 1'b0;
            rdata_latch <= 1'b0;
            wdata_latch <= 1'b0;
        end else begin
            if (step_rise)
                step_latch <= 1'b1;
            else if (i_input_reg_read || soft_rst)
                step_latch <= 1'b0;
            if (write_gate_out_rise)
                write_gate_out_latch <= 1'b1;
            else if (i_input_reg_read)
                write_gate_out_latch <= 1'b0;
            // Write data latch ignores write gate on purpose
            if (rdata_fall)
                rdata_latch <= 1'b1;
            else if (i_input_reg_read)
                rdata_latch <= 1'b0;
            if (wdata_fall)
                wdata_latch <= 1'b1;
            else if (i_input_reg_read)
                wdata_latch <= 1'b0;
        end
    end

    // ==========================================================
    // Status layouts per mode
    always @* begin
        if (mode_ext) begin
            next_status_a = {i_disk_interrupt_out, `FDSOR_BIT_ONE, i_step, ~track_zero_in_s,
                i_head_side_select, ~idx_s, ~wp_s, i_step_dir};
            next_status_b = {`FDSOR_BIT_ONE, `FDSOR_BIT_ONE,
                out_reg[`FDSOR_OUT_SEL_LO], wdata_toggle, rdata_toggle,
                i_write_gate_out, out_reg[`FDSOR_OUT_MOTOR_OUT_1],
                out_reg[`FDSOR_OUT_MOTOR_OUT_0]};
        end else begin
            next_status_a = {i_disk_interrupt_out, i_dma_request, step_latch, track_zero_in_s,
                ~i_head_side_select, idx_s, wp_s, ~i_step_dir};
            next_status_b = {`FDSOR_BIT_ONE, fdsor_ds_n(sel, 1'b1), fdsor_ds_n(sel, 1'b0),
                wdata_latch, rdata_latch, write_gate_out_latch,
                `FDSOR_BIT_ONE, `FDSOR_BIT_ONE};
        end
    end

    // ==========================================================
    // Read decode; basic-mode status reads and unmapped addresses float the bus
    always @* begin
        next_rdata = `FDSOR_BYTE_ZERO;
        next_oe = 1'b0;
        if (i_rd) begin
            case (i_addr)
                `FDSOR_ADDR_STATUS_A: begin
                    next_rdata = next_status_a;
                    next_oe = mode_ext | mode_alt;
                end
                `FDSOR_ADDR_STATUS_B: begin
                    next_rdata = next_status_b;
                    next_oe = mode_ext | mode_alt;
                end
                `FDSOR_ADDR_OUTPUT: begin
                    next_rdata = {2'b00, out_reg} & `FDSOR_OUT_IMPL;
                    next_oe = 1'b1;
                end
                default: begin
                    next_rdata = `FDSOR_BYTE_ZERO;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered outputs
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= `FDSOR_BYTE_ZERO;
            o_rdata_oe <= 1'b0;
            o_drive_select_0_n <= 1'b1;
            o_drive_select_1_n <= 1'b1;
            o_motor_out_0 <= 1'b0;
            o_motor_out_1 <= 1'b0;
            o_soft_reset_n <= 1'b0;
            o_dma_request <= 1'b0;
            // Extended mode keeps the pins enabled even while reset is held
            o_dma_request_oe <= mode_ext;
            o_disk_interrupt_out <= 1'b0;
            o_disk_interrupt_oe <= mode_ext;
            o_dma_ack_n <= 1'b1;
            o_terminal_count <= 1'b0;
        end else begin
            o_rdata <= next_rdata;
            o_rdata_oe <= next_oe;
            o_drive_select_0_n <= fdsor_ds_n(sel, 1'b0);
            o_drive_select_1_n <= fdsor_ds_n(sel, 1'b1);
            o_motor_out_0 <= out_reg[`FDSOR_OUT_MOTOR_OUT_0];
            o_motor_out_1 <= out_reg[`FDSOR_OUT_MOTOR_OUT_1];
            // Held low as long as the bit is low; hold time is the host's duty
            o_soft_reset_n <= out_reg[`FDSOR_OUT_NRST];
            o_dma_request <= i_dma_request;
            o_dma_request_oe <= pins_en;
            o_disk_interrupt_out <= i_disk_interrupt_out;
            o_disk_interrupt_oe <= pins_en;
            o_dma_ack_n <= dack_n_s | ~pins_en;
            o_terminal_count <= tc_s & pins_en;
        end
    end

endmodule
